// ===== rtl/pogd_consts.vh
`ifndef POGD_CONSTS_VH
`define POGD_CONSTS_VH
// Register addresses on the serial port
`define POGD_ADDR_EXP_SYNC 7'h29
`define POGD_ADDR_OFF_LO 7'h64
`define POGD_ADDR_OFF_HI 7'h65
`define POGD_ADDR_GAIN_SEL 7'h66
`define POGD_ADDR_SLOPE 7'h67
`define POGD_ADDR_BLANK_CNT 7'h76
`define POGD_ADDR_DBL_REF 7'h79
// Reset values
`define POGD_RST_EXP_SYNC 8'h00
`define POGD_RST_OFFSET 14'h3fc3
`define POGD_RST_GAIN_SEL 8'h00
`define POGD_RST_SLOPE 8'h20
`define POGD_RST_BLANK_CNT 8'h00
`define POGD_RST_DBL_REF 8'h00
// Field positions
`define POGD_BIT_DUAL 1
`define POGD_BIT_SYNC 2
`define POGD_BIT_DOUBLE 0
`define POGD_BIT_BLACK 1
`define POGD_OFF_HI_W 6
// Converter and pixel constants
`define POGD_ADC_OFFSET 16'sh0046
`define POGD_MAX_12 16'sh0fff
`define POGD_MAX_10 16'sh03ff
`define POGD_BLACK_COLS 5'h10
// Serial frame: one write flag, seven address bits, eight data bits
`define POGD_SPI_HDR_BITS 5'h08
`define POGD_SPI_ALL_BITS 5'h10
`endif

// ===== rtl/pogd_top.v
`timescale 1ns/1ns
`include "pogd_consts.vh"

// Pixel FIFO with registered head, so the drain side sees flop outputs
module pogd_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output reg in_ready,
  output reg out_valid,
  output reg [WIDTH-1:0] out_data,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr, rd_ptr;
  reg [AW:0] count;
  wire push, pop;
  wire [AW:0] next_count;
  assign push = in_valid && in_ready;
  // Refill the head whenever it is empty or being taken
  assign pop = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);
  // Ready comes from a flop, fed by the next fill level to keep timing
  assign next_count = (push && !pop) ? count + 1'b1 :
    (pop && !push) ? count - 1'b1 : count;

  // Storage array holds no reset, pointers do
  always @(posedge mclk) begin
    if (ce && push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else if (ce) begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
        out_data <= mem[rd_ptr];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      count <= next_count;
      in_ready <= (next_count != DEPTH[AW:0]);
    end
  end
endmodule

module pogd_top #(
  parameter PIX_W = 12,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  input wire spi_clk,
  input wire spi_cs_n,
  input wire spi_mosi,
  output reg spi_miso,
  input wire resolution_12bit,
  input wire xfer_pulse,
  input wire frame_in,
  input wire row_in,
  input wire pix_in_valid,
  input wire [PIX_W-1:0] pix_in_data,
  output wire pix_in_ready,
  output reg frame_valid,
  output reg line_valid,
  output reg pixel_valid,
  output reg [PIX_W-1:0] pixel_data,
  input wire pixel_ready,
  output reg [1:0] column_amp_gain,
  output reg gain_double,
  output reg [5:0] column_amp_gain_x10,
  output reg [7:0] ramp_slope,
  output reg black_ref_en,
  output reg in_dummy_row
);
  // Register storage
  reg [7:0] exposure_sync_control;
  reg [13:0] dark_level_offset;
  reg [7:0] column_amp_gain_select;
  reg [7:0] converter_ramp_slope;
  reg [7:0] blank_row_count;
  reg [7:0] gain_double_and_black_ref;
  // Serial port state
  reg sclk_d;
  reg [4:0] bit_cnt;
  reg [15:0] shift_in;
  reg [7:0] shift_out;
  // Readout timing state
  reg xfer_d, row_d, frame_d;
  reg [7:0] dummy_left;
  reg [4:0] col_cnt;
  reg signed [13:0] active_offset;
  reg [PIX_W-1:0] cond_pix;
  wire sclk_rise, sclk_fall, xfer_fire, row_rise, frame_rise;
  wire [15:0] next_shift;
  wire [PIX_W-1:0] raw_pix, fifo_data;
  wire signed [15:0] sum_pix, max_pix;
  wire fifo_valid, fifo_take;

  // Readback mux; upper offset bits above six read as zero
  function [7:0] reg_read;
    input [6:0] addr;
    begin
      case (addr)
        `POGD_ADDR_EXP_SYNC: reg_read = exposure_sync_control;
        `POGD_ADDR_OFF_LO: reg_read = dark_level_offset[7:0];
        `POGD_ADDR_OFF_HI: reg_read = {2'h0, dark_level_offset[13:8]};
        `POGD_ADDR_GAIN_SEL: reg_read = column_amp_gain_select;
        `POGD_ADDR_SLOPE: reg_read = converter_ramp_slope;
        `POGD_ADDR_BLANK_CNT: reg_read = blank_row_count;
        `POGD_ADDR_DBL_REF: reg_read = gain_double_and_black_ref;
        default: reg_read = 8'h00;
      endcase
    end
  endfunction
  // Gain in tenths: 10/12/14/16, doubled when asked
  function [5:0] gain_x10;
    input [1:0] sel;
    input dbl;
    reg [5:0] base;
    begin
      case (sel)
        2'h0: base = 6'h0a;
        2'h1: base = 6'h0c;
        2'h2: base = 6'h0e;
        2'h3: base = 6'h10;
        default: base = 6'h0a;
      endcase
      gain_x10 = dbl ? {base[4:0], 1'b0} : base;
    end
  endfunction
  // Port pins are synchronous to mclk, so plain edge detection suffices
  assign sclk_rise = spi_clk && !sclk_d;
  assign sclk_fall = !spi_clk && sclk_d;
  assign next_shift = {shift_in[14:0], spi_mosi};
  // Serial slave: write flag, address, then data, MSB first
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d <= 1'b0;
      bit_cnt <= 5'h00;
      shift_in <= 16'h0000;
      shift_out <= 8'h00;
      spi_miso <= 1'b0;
      exposure_sync_control <= `POGD_RST_EXP_SYNC;
      dark_level_offset <= `POGD_RST_OFFSET;
      column_amp_gain_select <= `POGD_RST_GAIN_SEL;
      converter_ramp_slope <= `POGD_RST_SLOPE;
      blank_row_count <= `POGD_RST_BLANK_CNT;
      gain_double_and_black_ref <= `POGD_RST_DBL_REF;
    end else if (ce) begin
      sclk_d <= spi_clk;
      if (spi_cs_n) begin
        // Deselect aborts any partial frame
        bit_cnt <= 5'h00;
        spi_miso <= 1'b0;
      end else if (sclk_rise && bit_cnt != `POGD_SPI_ALL_BITS) begin
        shift_in <= next_shift;
        bit_cnt <= bit_cnt + 5'h01;
        if (bit_cnt == `POGD_SPI_HDR_BITS - 5'h01) begin
          shift_out <= reg_read(next_shift[6:0]);
        end
        if (bit_cnt == `POGD_SPI_ALL_BITS - 5'h01 && next_shift[15]) begin
          case (next_shift[14:8])
            `POGD_ADDR_EXP_SYNC: exposure_sync_control <= next_shift[7:0];
            `POGD_ADDR_OFF_LO: dark_level_offset[7:0] <= next_shift[7:0];
            `POGD_ADDR_OFF_HI:
              dark_level_offset[13:8] <= next_shift[5:0];
            `POGD_ADDR_GAIN_SEL: column_amp_gain_select <= next_shift[7:0];
            `POGD_ADDR_SLOPE: converter_ramp_slope <= next_shift[7:0];
            `POGD_ADDR_BLANK_CNT: blank_row_count <= next_shift[7:0];
            `POGD_ADDR_DBL_REF:
              gain_double_and_black_ref <= next_shift[7:0];
            default: bit_cnt <= bit_cnt + 5'h01;
          endcase
        end
      end else if (sclk_fall && bit_cnt >= `POGD_SPI_HDR_BITS &&
                   bit_cnt != `POGD_SPI_ALL_BITS) begin
        // Read data shifts out on falling edges after the header
        spi_miso <= shift_out[7];
        shift_out <= {shift_out[6:0], 1'b0};
      end
    end
  end

  // Analog settings go out as registered levels
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      column_amp_gain <= 2'h0;
      gain_double <= 1'b0;
      column_amp_gain_x10 <= 6'h0a;
      ramp_slope <= `POGD_RST_SLOPE;
      black_ref_en <= 1'b0;
    end else if (ce) begin
      column_amp_gain <= column_amp_gain_select[1:0];
      gain_double <= gain_double_and_black_ref[`POGD_BIT_DOUBLE];
      column_amp_gain_x10 <= gain_x10(column_amp_gain_select[1:0],
        gain_double_and_black_ref[`POGD_BIT_DOUBLE]);
      ramp_slope <= converter_ramp_slope;
      black_ref_en <= gain_double_and_black_ref[`POGD_BIT_BLACK];
    end
  end

  // Dummy rows only when sync bit and a nonzero count are both loaded
  assign xfer_fire = exposure_sync_control[`POGD_BIT_SYNC] &&
    (blank_row_count != 8'h00) &&
    ((xfer_pulse && !xfer_d) ||
     (exposure_sync_control[`POGD_BIT_DUAL] && !xfer_pulse && xfer_d));
  assign row_rise = row_in && !row_d;
  assign frame_rise = frame_in && !frame_d;

  // Row bookkeeping: each row period, dummy or not, is one line slot
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_d <= 1'b0;
      row_d <= 1'b0;
      frame_d <= 1'b0;
      dummy_left <= 8'h00;
      in_dummy_row <= 1'b0;
      col_cnt <= 5'h00;
      active_offset <= `POGD_RST_OFFSET;
      frame_valid <= 1'b0;
      line_valid <= 1'b0;
    end else if (ce) begin
      xfer_d <= xfer_pulse;
      row_d <= row_in;
      frame_d <= frame_in;
      if (frame_rise) begin
        // Offset changes only between frames to keep a frame uniform
        active_offset <= dark_level_offset;
      end
      if (row_rise) begin
        col_cnt <= 5'h00;
        if (xfer_fire) begin
          // Pulse during row start: this row already counts as dummy
          in_dummy_row <= 1'b1;
          dummy_left <= blank_row_count - 8'h01;
        end else if (dummy_left != 8'h00) begin
          in_dummy_row <= 1'b1;
          dummy_left <= dummy_left - 8'h01;
        end else begin
          in_dummy_row <= 1'b0;
        end
      end else begin
        if (xfer_fire) begin
          dummy_left <= blank_row_count;
        end
        if (pix_in_valid && pix_in_ready && col_cnt != `POGD_BLACK_COLS) begin
          col_cnt <= col_cnt + 5'h01;
        end
      end
      frame_valid <= frame_in;
      line_valid <= row_in && !(row_rise ? (xfer_fire ||
        dummy_left != 8'h00) : in_dummy_row);
    end
  end

  // Black columns replace the sample, leaving only the dark level
  assign raw_pix = (black_ref_en && col_cnt < `POGD_BLACK_COLS) ?
    {PIX_W{1'b0}} : pix_in_data;
  // Signed sum: sample plus fixed 70 plus sign-extended offset
  assign sum_pix = $signed({{(16-PIX_W){1'b0}}, raw_pix}) +
    `POGD_ADC_OFFSET + {{2{active_offset[13]}}, active_offset};
  assign max_pix = resolution_12bit ? `POGD_MAX_12 : `POGD_MAX_10;

  // Clamp to the output range of the current resolution
  always @* begin
    cond_pix = sum_pix[PIX_W-1:0];
    if (sum_pix < 16'sh0000) begin
      cond_pix = {PIX_W{1'b0}};
    end else if (sum_pix > max_pix) begin
      cond_pix = max_pix[PIX_W-1:0];
    end
  end

  // Samples are dropped before the buffer while in_dummy_row is set, which lags row start by one cycle
  pogd_fifo #(
    .WIDTH(PIX_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) pogd_fifo_inst (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(pix_in_valid && row_in && !in_dummy_row),
    .in_data(cond_pix),
    .in_ready(pix_in_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_take)
  );
  assign fifo_take = !pixel_valid || pixel_ready;
  // Output stage keeps every outgoing strobe on a flop
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pixel_valid <= 1'b0;
      pixel_data <= {PIX_W{1'b0}};
    end else if (ce && fifo_take) begin
      pixel_valid <= fifo_valid;
      pixel_data <= fifo_data;
    end
  end
endmodule

// ===== testbench/pogd_rx_model.sv
`timescale 1ns/1ns
// Capture side: finds lines and pixels from strobes, may stall
module pogd_rx_model (
  input wire mclk,
  input wire rst_n,
  input wire stall,
  input wire line_valid,
  input wire pixel_valid,
  input wire [11:0] pixel_data,
  output reg pixel_ready
);
  logic [11:0] got[$];
  int lines;
  logic lv_q;
  // No fixed row timing assumed; each rising edge of line_valid counts a line
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lines <= 0;
      lv_q <= 1'b0;
      pixel_ready <= 1'b0;
    end else begin
      lv_q <= line_valid;
      pixel_ready <= !stall;
      if (line_valid && !lv_q) lines <= lines + 1;
      if (pixel_valid && pixel_ready) got.push_back(pixel_data);
    end
  end
endmodule

// ===== testbench/pogd_top_sva.sv
`timescale 1ns/1ns
// Port-level checks on the conditioning block
module pogd_top_sva #(
  parameter PIX_W = 12
) (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  input wire spi_cs_n,
  input wire spi_miso,
  input wire resolution_12bit,
  input wire frame_in,
  input wire row_in,
  input wire frame_valid,
  input wire line_valid,
  input wire pixel_valid,
  input wire [PIX_W-1:0] pixel_data,
  input wire pixel_ready,
  input wire [1:0] column_amp_gain,
  input wire gain_double,
  input wire [5:0] column_amp_gain_x10,
  input wire in_dummy_row
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  line_low_a: assert property (
    in_dummy_row |-> !line_valid) else $error("line strobe in dummy row");
  line_src_a: assert property (
    $rose(line_valid) |-> $past(row_in)) else $error("line without row");
  line_end_a: assert property (
    $fell(line_valid) |-> !$past(row_in) || in_dummy_row
      || $past(in_dummy_row)) else $error("line cut short");
  gain_x10_a: assert property (
    $stable(column_amp_gain) && $stable(gain_double) |->
      column_amp_gain_x10 == ({3'h0, column_amp_gain, 1'b0} + 6'h0a)
      << gain_double) else $error("gain decode wrong");
  pix_hold_a: assert property (
    pixel_valid && !pixel_ready |=> pixel_valid && $stable(pixel_data))
    else $error("pixel dropped under stall");
  clamp_ten_a: assert property (
    pixel_valid && !resolution_12bit |-> pixel_data <= 12'h3ff)
    else $error("ten bit clamp broken");
  miso_idle_a: assert property (
    spi_cs_n [*2] |-> !spi_miso) else $error("miso busy when idle");
  frame_keep_a: assert property (
    ce |=> frame_valid == $past(frame_in)) else $error("frame strobe off");
endmodule

// ===== testbench/test_pixel_offset_gain_dummy_rows.sv
`timescale 1ns/1ns
module test_pixel_offset_gain_dummy_rows;
  logic mclk = 0, rst_n = 0, ce = 1, spi_clk = 0, spi_cs_n = 1;
  logic spi_mosi = 0, resolution_12bit = 1, xfer_pulse = 0;
  logic frame_in = 0, row_in = 0, pix_in_valid = 0, stall = 0;
  logic [11:0] pix_in_data = 0, pixel_data;
  wire spi_miso, pix_in_ready, frame_valid, line_valid, pixel_valid;
  wire pixel_ready, gain_double, black_ref_en, in_dummy_row;
  wire [1:0] column_amp_gain;
  wire [5:0] column_amp_gain_x10;
  wire [7:0] ramp_slope;
  int error_cnt = 0, samples_checked = 0;

  pogd_top pogd_top_inst (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .resolution_12bit(resolution_12bit),
    .xfer_pulse(xfer_pulse), .frame_in(frame_in), .row_in(row_in),
    .pix_in_valid(pix_in_valid), .pix_in_data(pix_in_data),
    .pix_in_ready(pix_in_ready), .frame_valid(frame_valid),
    .line_valid(line_valid), .pixel_valid(pixel_valid),
    .pixel_data(pixel_data), .pixel_ready(pixel_ready),
    .column_amp_gain(column_amp_gain), .gain_double(gain_double),
    .column_amp_gain_x10(column_amp_gain_x10), .ramp_slope(ramp_slope),
    .black_ref_en(black_ref_en), .in_dummy_row(in_dummy_row));
  pogd_rx_model pogd_rx_model_inst (.mclk(mclk), .rst_n(rst_n),
    .stall(stall), .line_valid(line_valid), .pixel_valid(pixel_valid),
    .pixel_data(pixel_data), .pixel_ready(pixel_ready));

  // Clock, 8 ns period
  initial begin
    forever #4 mclk = ~mclk;
  end

  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // Serial frame, slow clock so mclk sees every level
  task spi(input logic [15:0] f, output logic [7:0] d);
    int i;
    spi_cs_n = 0;
    for (i = 15; i >= 0; i--) begin
      spi_mosi = f[i];
      spi_clk = 0;
      repeat (4) @(negedge mclk);
      if (i < 8) d[i] = spi_miso;
      spi_clk = 1;
      repeat (4) @(negedge mclk);
    end
    spi_clk = 0;
    repeat (4) @(negedge mclk);
    spi_cs_n = 1;
    repeat (4) @(negedge mclk);
  endtask

  task wr(input logic [6:0] a, input logic [7:0] v);
    logic [7:0] d;
    spi({1'b1, a, v}, d);
  endtask

  task rchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    spi({1'b0, a, 8'h00}, d);
    chk("miso idle", 16'h0000, {15'h0000, spi_miso});
    chk("read data", e, d);
  endtask

  // One row; waits on back-pressure with a bound
  task row(input int n, input logic [11:0] raw);
    int i, g;
    row_in = 1;
    i = 0;
    for (g = 0; i < n && g < 99; g++) begin
      @(negedge mclk);
      pix_in_valid = pix_in_ready;
      pix_in_data = raw;
      if (pix_in_ready) i++;
    end
    chk("row accepted", n, i);
    if (i != n) finish_test;
    @(negedge mclk);
    pix_in_valid = 0;
    row_in = 0;
    repeat (6) @(negedge mclk);
  endtask

  // New frame so a fresh offset is taken up
  task px(input int n, input logic [11:0] raw);
    pogd_rx_model_inst.got.delete();
    frame_in = 0;
    repeat (2) @(negedge mclk);
    frame_in = 1;
    row(n, raw);
  endtask

  task t_regs;
    int l0;
    rchk(7'h64, 8'hc3);
    rchk(7'h65, 8'h3f);
    rchk(7'h66, 8'h00);
    rchk(7'h67, 8'h20);
    rchk(7'h76, 8'h00);
    rchk(7'h29, 8'h00);
    rchk(7'h79, 8'h00);
    rchk(7'h10, 8'h00);
    l0 = pogd_rx_model_inst.lines;
    xfer_pulse = 1;
    row(1, 12'h000);
    xfer_pulse = 0;
    chk("lines", 1, pogd_rx_model_inst.lines - l0);
  endtask

  task t_fill;
    int n, g;
    pogd_rx_model_inst.got.delete();
    stall = 1;
    row_in = 1;
    n = 0;
    for (g = 0; g < 20; g++) begin
      @(negedge mclk);
      pix_in_valid = pix_in_ready;
      pix_in_data = n[11:0];
      if (pix_in_ready) n++;
    end
    @(negedge mclk);
    pix_in_valid = 0;
    row_in = 0;
    chk("refused", 0, pix_in_ready);
    chk("depth", 1, n >= 8);
    stall = 0;
    repeat (30) @(negedge mclk);
    chk("drained", n, pogd_rx_model_inst.got.size());
    chk("last", n + 8, pogd_rx_model_inst.got[n-1]);
  endtask

  task t_offset;
    px(2, 12'h064);
    chk("dark", 12'h06d, pogd_rx_model_inst.got[1]);
    wr(7'h64, 8'h00);
    wr(7'h65, 8'h20);
    px(2, 12'hfa0);
    chk("low clamp", 0, pogd_rx_model_inst.got[1]);
    wr(7'h64, 8'hff);
    wr(7'h65, 8'hdf);
    rchk(7'h65, 8'h1f);
    px(2, 12'h000);
    chk("top clamp", 12'hfff, pogd_rx_model_inst.got[1]);
    resolution_12bit = 0;
    px(2, 12'h000);
    chk("ten bit", 12'h3ff, pogd_rx_model_inst.got[1]);
    resolution_12bit = 1;
  endtask

  task t_gain;
    int s, d;
    for (s = 0; s < 4; s++) begin
      for (d = 0; d < 2; d++) begin
        wr(7'h66, s[7:0]);
        wr(7'h79, d[7:0]);
        repeat (3) @(negedge mclk);
        chk("gain", (10 + 2 * s) * (d + 1), column_amp_gain_x10);
        chk("gain sel", s, column_amp_gain);
        chk("double", d, gain_double);
      end
    end
    wr(7'h67, 8'h40);
    repeat (3) @(negedge mclk);
    chk("slope", 8'h40, ramp_slope);
    // Clock enable low: a whole write must leave no trace
    ce = 0;
    wr(7'h67, 8'h55);
    ce = 1;
    repeat (3) @(negedge mclk);
    chk("frozen", 8'h40, ramp_slope);
  endtask

  task t_black;
    wr(7'h64, 8'h00);
    wr(7'h65, 8'h00);
    wr(7'h79, 8'h02);
    chk("black en", 1, black_ref_en);
    px(18, 12'h010);
    chk("black col", 12'h046, pogd_rx_model_inst.got[15]);
    chk("live col", 12'h056, pogd_rx_model_inst.got[16]);
    wr(7'h79, 8'h00);
  endtask

  // Dual exposure: two dummy rows after each transfer toggle
  task t_dummy;
    int l0;
    wr(7'h76, 8'h02);
    wr(7'h29, 8'h06);
    px(0, 12'h000);
    l0 = pogd_rx_model_inst.lines;
    xfer_pulse = 1;
    repeat (3) row(3, 12'h010);
    xfer_pulse = 0;
    repeat (3) row(3, 12'h010);
    chk("lines", 2, pogd_rx_model_inst.lines - l0);
    chk("kept", 6, pogd_rx_model_inst.got.size());
  endtask

  // Watchdog: a hang counts as a mismatch
  initial begin
    #400000;
    error_cnt++;
    finish_test;
  end

  initial begin
    repeat (3) @(negedge mclk);
    rst_n = 1;
    @(negedge mclk);
    t_regs;
    t_fill;
    t_offset;
    t_gain;
    t_black;
    t_dummy;
    finish_test;
  end
endmodule

bind pogd_top pogd_top_sva #(.PIX_W(PIX_W)) pogd_top_sva_inst (.*);
